/* File: src/gpc_top.v */
// gpio pad configuration, rail select and port 3 data registers
`default_nettype none
`include "gpc_defines.vh"
module gpc_top #(
  parameter [4:0] ANALOG_FUNC = `GPC_FUNC_ANALOG
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [31:0] addr,
  input wire [15:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [15:0] rdata,
  input wire [7:0] port3_pin_in,
  output wire [7:0] port3_pin_out,
  output wire [7:0] port3_pin_oe,
  output wire [7:0] port0_rail_sel,
  output wire [5:0] port1_rail_sel,
  output wire [9:0] port2_rail_sel,
  output wire [7:0] port3_rail_sel,
  output wire [1:0] pin_pull_up,
  output wire [1:0] pin_pull_down,
  output wire [1:0] pin_out_en,
  output wire [1:0] pin_analog,
  output wire [9:0] pin_function_sel
);
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n;
  // release synchronised, assertion stays asynchronous
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // pins are asynchronous to sys_clk
  reg [7:0] pin_s1_q;
  reg [7:0] pin_s2_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else begin
      pin_s1_q <= port3_pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  reg [1:0] pull_direction_sel_q [0:1];
  reg [4:0] func_q [0:1];
  reg [7:0] p0_rail_q;
  reg [5:0] p1_rail_q;
  reg [9:0] p2_rail_q;
  reg [7:0] p3_rail_q;
  reg [7:0] port3_level_q;
  reg [7:0] port3_level_d;
  reg [15:0] rdata_d;
  wire [31:0] cfg_addr [0:1];
  assign cfg_addr[0] = `GPC_ADDR_P29_CFG;
  assign cfg_addr[1] = `GPC_ADDR_P30_CFG;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_cfg
      wire analog = (func_q[i] == ANALOG_FUNC);
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pull_direction_sel_q[i] <= `GPC_PULL_DIRECTION_SEL_RESET;
          func_q[i] <= `GPC_FUNC_RESET;
        end else if (wr_en && addr == cfg_addr[i]) begin
          pull_direction_sel_q[i] <= wdata[`GPC_PULL_DIRECTION_SEL_HI:`GPC_PULL_DIRECTION_SEL_LO];
          func_q[i] <= wdata[`GPC_FUNC_HI:`GPC_FUNC_LO];
        end
      end
      // analog pads ignore the pull field entirely
      assign pin_pull_up[i] = !analog && pull_direction_sel_q[i] == `GPC_PULL_DIRECTION_SEL_PU;
      assign pin_pull_down[i] = !analog && pull_direction_sel_q[i] == `GPC_PULL_DIRECTION_SEL_PD;
      assign pin_out_en[i] = !analog && pull_direction_sel_q[i] == `GPC_PULL_DIRECTION_SEL_OUT;
      assign pin_analog[i] = analog;
      assign pin_function_sel[5*i+4:5*i] = func_q[i];
    end
  endgenerate

  // rail registers; buck-mode safety is left to software, no hardware interlock
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_rail_q <= 8'h00;
      p1_rail_q <= 6'h00;
      p2_rail_q <= 10'h000;
      p3_rail_q <= 8'h00;
    end else if (wr_en) begin
      if (addr == `GPC_ADDR_P01_RAIL) begin
        p0_rail_q <= wdata[`GPC_P0_HI:`GPC_P0_LO];
        p1_rail_q <= wdata[`GPC_P1_HI:`GPC_P1_LO];
      end
      if (addr == `GPC_ADDR_P2_RAIL) begin
        p2_rail_q <= wdata[`GPC_P2_HI:0];
      end
      if (addr == `GPC_ADDR_P3_RAIL) begin
        p3_rail_q <= wdata[`GPC_P3_HI:0];
      end
    end
  end
  assign port0_rail_sel = p0_rail_q;
  assign port1_rail_sel = p1_rail_q;
  assign port2_rail_sel = p2_rail_q;
  assign port3_rail_sel = p3_rail_q;

  always @* begin
    port3_level_d = port3_level_q;
    if (wr_en && addr == `GPC_ADDR_P3_LEVEL) begin
      port3_level_d = wdata[`GPC_P3_HI:0];
    end else if (wr_en && addr == `GPC_ADDR_PORT3_SET_BITS) begin
      port3_level_d = port3_level_q | wdata[`GPC_P3_HI:0];
    end else if (wr_en && addr == `GPC_ADDR_P3_CLR) begin
      port3_level_d = port3_level_q & ~wdata[`GPC_P3_HI:0];
    end
  end
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port3_level_q <= 8'h00;
    end else begin
      port3_level_q <= port3_level_d;
    end
  end
  assign port3_pin_out = port3_level_q;
  // port 3 pin 0 direction comes from the P30 pin config only; others stay driven
  assign port3_pin_oe = {7'h7F, pin_out_en[1]};

  always @* begin
    rdata_d = `GPC_ZERO16;
    if (rd_en) begin
      case (addr)
        `GPC_ADDR_P29_CFG: rdata_d = {6'h00, pull_direction_sel_q[0], 3'h0, func_q[0]};
        `GPC_ADDR_P30_CFG: rdata_d = {6'h00, pull_direction_sel_q[1], 3'h0, func_q[1]};
        `GPC_ADDR_P01_RAIL: rdata_d = {2'h0, p1_rail_q, p0_rail_q};
        `GPC_ADDR_P2_RAIL: rdata_d = {6'h00, p2_rail_q};
        `GPC_ADDR_P3_RAIL: rdata_d = {8'h00, p3_rail_q};
        `GPC_ADDR_P3_LEVEL: rdata_d = {8'h00, pin_s2_q};
        `GPC_ADDR_PORT3_SET_BITS: rdata_d = `GPC_ZERO16;
        `GPC_ADDR_P3_CLR: rdata_d = `GPC_ZERO16;
        default: rdata_d = `GPC_ZERO16;
      endcase
    end
  end
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `GPC_ZERO16;
    end else begin
      rdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

/* File: src/gpc_defines.vh */
// register map, field layout and reset values of the gpio pad config block
// Contract
// - pull/direction field 9:8 decodes: 00 in, 01 pull-up, 10 pull-down, 11 output.
// - pull/direction field resets to 2: input with pull-down.
// - analog function makes the pull/direction field irrelevant to the pad.
// - port 0 rail select at bits 7:0 of the port 0/1 rail register.
// - port 1 rail select at bits 13:8, bit 8 is pin 0.
// - port 2 rail select at bits 9:0, bits 15:10 reserved.
// - port 3 rail select at bits 7:0, bits 15:8 reserved.
// - rail bit set selects 1 V, clear selects 3 V; reset clears all.
// - port 3 data write loads latch; read returns pin levels; latch resets zero.
// - set register write sets latch bits written one; reads zero.
// - clear register write clears latch bits written one; reads zero.
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH
`define GPC_AW 32
`define GPC_DW 16
`define GPC_ADDR_P29_CFG 32'h50003058
`define GPC_ADDR_P01_RAIL 32'h50003070
`define GPC_ADDR_P2_RAIL 32'h50003072
`define GPC_ADDR_P3_RAIL 32'h50003074
`define GPC_ADDR_P3_LEVEL 32'h50003080
`define GPC_ADDR_PORT3_SET_BITS 32'h50003082
`define GPC_ADDR_P3_CLR 32'h50003084
`define GPC_ADDR_P30_CFG 32'h50003086
`define GPC_PULL_DIRECTION_SEL_HI 9
`define GPC_PULL_DIRECTION_SEL_LO 8
`define GPC_FUNC_HI 4
`define GPC_FUNC_LO 0
`define GPC_P0_HI 7
`define GPC_P0_LO 0
`define GPC_P1_HI 13
`define GPC_P1_LO 8
`define GPC_P2_HI 9
`define GPC_P3_HI 7
`define GPC_PULL_DIRECTION_SEL_RESET 2'h2
`define GPC_PULL_DIRECTION_SEL_IN 2'h0
`define GPC_PULL_DIRECTION_SEL_PU 2'h1
`define GPC_PULL_DIRECTION_SEL_PD 2'h2
`define GPC_PULL_DIRECTION_SEL_OUT 2'h3
`define GPC_FUNC_RESET 5'h00
`define GPC_FUNC_GPIO 5'h00
`define GPC_FUNC_ANALOG 5'h0F
`define GPC_ZERO16 16'h0000
`endif

/* File: tb/gpc_props.sv */
// port assertions for the pad config block
`default_nettype none
`include "gpc_defines.vh"
module gpc_props #(
  parameter [4:0] ANALOG_FUNC = 5'h0F
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [31:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rdata,
  input wire logic [7:0] port3_pin_out,
  input wire logic [7:0] port3_pin_oe,
  input wire logic [7:0] port3_rail_sel,
  input wire logic [1:0] pin_pull_up,
  input wire logic [1:0] pin_pull_down,
  input wire logic [1:0] pin_out_en,
  input wire logic [1:0] pin_analog,
  input wire logic [9:0] pin_function_sel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_LVL: assert property (wr_en && addr == `GPC_ADDR_P3_LEVEL |=>
    port3_pin_out == $past(wdata[7:0])) else $error("latch load");
  AST_SET: assert property (wr_en && addr == `GPC_ADDR_PORT3_SET_BITS |=>
    port3_pin_out == ($past(port3_pin_out) | $past(wdata[7:0]))) else $error("set");
  AST_CLR: assert property (wr_en && addr == `GPC_ADDR_P3_CLR |=>
    port3_pin_out == ($past(port3_pin_out) & ~$past(wdata[7:0]))) else $error("clear");
  AST_RZ: assert property (rd_en && addr[15:0] inside {16'h3082, 16'h3084} |=>
    rdata == 16'h0000) else $error("set/clear read");
  AST_RAIL: assert property (wr_en && addr == `GPC_ADDR_P3_RAIL |=>
    port3_rail_sel == $past(wdata[7:0])) else $error("rail");
  AST_PULL: assert property ($onehot0({pin_pull_up[0], pin_pull_down[0], pin_out_en[0]}))
    else $error("pull decode");
  AST_OE: assert property (port3_pin_oe[0] == pin_out_en[1]) else $error("oe");
  AST_ANA: assert property (pin_analog[0] == (pin_function_sel[4:0] == ANALOG_FUNC))
    else $error("analog");
  cover property (wr_en && addr == `GPC_ADDR_PORT3_SET_BITS);
  cover property (wr_en && addr == `GPC_ADDR_P3_CLR);
  cover property (pin_analog[0]);
endmodule
bind gpc_top gpc_props #(.ANALOG_FUNC(ANALOG_FUNC)) u_props (.*);
`default_nettype wire

/* File: tb/gpc_pad_model.sv */
// far-side pad model for port 3
`default_nettype none
module gpc_pad_model (
  input wire logic [7:0] drv,
  input wire logic [7:0] oe,
  input wire logic pu,
  input wire logic pd,
  input wire logic ext_en,
  input wire logic ext_val,
  output logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin[7:1] = drv[7:1];
  // a floating pin shows the inverse so a stale latch never passes as a level
  assign pin[0] = oe[0] ? drv[0] : ext_en ? ext_val : pu | (~pd & ~drv[0]);
endmodule
`default_nettype wire

/* File: tb/tb_gpc_top.sv */
// self-checking bench for the gpio pad config block
`default_nettype none
`include "gpc_defines.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb_gpc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, reset_n = 0, wr_en = 0, rd_en = 0, ext_en = 0, ext_val = 0;
  logic [31:0] addr = '0;
  logic [15:0] wdata = '0, rdata;
  logic [7:0] port3_pin_in, port3_pin_out, port3_pin_oe, port0_rail_sel, port3_rail_sel;
  logic [5:0] port1_rail_sel;
  logic [9:0] port2_rail_sel, pin_function_sel;
  logic [1:0] pin_pull_up, pin_pull_down, pin_out_en, pin_analog;
  int n_errors = 0, tests_run = 0;
  // rail writes assume boost mode, where the 1 V rail is allowed
  logic [63:0] rows [9] = '{64'h50003058FFFF031F, 64'h50003070FFFF3FFF,
    64'h50003072FFFF03FF, 64'h50003074FFFF00FF, 64'h5000308603000300,
    64'h5000308000A500A5, 64'h50003082005A0000, 64'h50003084000F0000,
    64'h50003060FFFF0000};
  gpc_top #(.ANALOG_FUNC(5'h0F)) dut (.*);
  gpc_pad_model pads (.drv(port3_pin_out), .oe(port3_pin_oe), .pu(pin_pull_up[1]),
    .pd(pin_pull_down[1]), .ext_en(ext_en), .ext_val(ext_val), .pin(port3_pin_in));
  initial forever #2 sys_clk = ~sys_clk;
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge sys_clk);
    wr_en <= 1'h0;
    // one idle edge so the next call never re-drives the strobe in this step
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge sys_clk);
    rd_en <= 1'h0;
    #1 `CHK(rdata, e)
    @(posedge sys_clk);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    `CHK({pin_pull_down, pin_out_en, pin_function_sel}, 14'h3000)
    `CHK({port0_rail_sel, port2_rail_sel, port3_rail_sel, port3_pin_out}, 34'h0)
    rd(`GPC_ADDR_P30_CFG, 16'h0200);
    for (int i = 0; i < 9; i++) begin
      wr(rows[i][63:32], rows[i][31:16]);
      repeat (3) @(posedge sys_clk);
      rd(rows[i][63:32], rows[i][15:0]);
    end
    `CHK({port0_rail_sel, port1_rail_sel, port2_rail_sel, port3_rail_sel}, 32'hFFFFFFFF)
    wr(`GPC_ADDR_PORT3_SET_BITS, 16'h000F);
    wr(`GPC_ADDR_P3_CLR, 16'h0080);
    #1 `CHK(port3_pin_out, 8'h7F)
    wr(`GPC_ADDR_P30_CFG, 16'h0000);
    ext_en <= 1'h1;
    repeat (3) @(posedge sys_clk);
    rd(`GPC_ADDR_P3_LEVEL, 16'h007E);
    for (int k = 0; k < 4; k++) begin
      wr(`GPC_ADDR_P29_CFG, 16'(k << 8));
      #1 `CHK({pin_out_en[0], pin_pull_down[0], pin_pull_up[0]}, 3'(k == 3 ? 4 : k))
    end
    wr(`GPC_ADDR_P29_CFG, 16'h010F);
    #1 `CHK({pin_analog[0], pin_pull_up[0], pin_out_en[0], pin_function_sel[4:0]}, 8'h8F)
    // mid-run reset must bring every register but the port 1 rail (unchecked) back to its reset value
    @(posedge sys_clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    `CHK({port0_rail_sel, port2_rail_sel, port3_rail_sel, port3_pin_out}, 34'h0)
    `CHK({pin_pull_down, pin_out_en, pin_function_sel}, 14'h3000)
    rd(`GPC_ADDR_P29_CFG, 16'h0200);
    summarize();
  end
endmodule
`default_nettype wire
